//--- src/vem_regs.sv
// module: mode and timing register bank with its control-side datapath pieces

//Function
// RQ1 - y level bit: 0 selects first broadcast levels, 1 selects SMPTE levels
// RQ2 - uv level: 01 is 700mV, 10 is 1000mV, 00 is standard default
// RQ3 - rgb sync bit puts sync on red, green and blue outputs
// RQ4 - clamp pulse shifted 0..3 cycles; direction bit 1 advances, 0 delays
// RQ5 - clamp position bit 1 back porch, 0 front porch
// RQ6 - both straps high at reset: sleep; power-up bit 1 hands over to sleep bit
// RQ7 - host writes pll control 0 whenever four-times oversampling is selected
// RQ8 - three-bit field counter readable; 0..3 in NTSC, 0..7 in PAL
// RQ9 - colour control enable applies contrast and saturation scales, else bypassed
// RQ10 - luma saturation clips luma at the scaled-255 level
// RQ11 - hue adjust enable rotates chroma phase, else no shift
// RQ12 - brightness enable adds set-up level to scaled luma, else nothing
// RQ13 - sharpness acts only with luma filter select at extended code 100
// RQ14 - sync pin select: 1 composite sync, 0 horizontal sync
// RQ15 - shared pin select: 1 clamp pulse, 0 vertical sync
// RQ16 - double buffer bit buffers picture registers, never in master timing
// RQ17 - port width bit selects 16-bit or 8-bit input on low pins
// RQ18 - noise reduction and gamma enables; curve select 0 is A, else B
// RQ19 - in 4x oversampling limiter floors -1.5, -6 or -11 IRE
// RQ20 - luma delay up to 6 clocks, chroma delay up to 8 clocks
// RQ21 - min luma bit 1 limits at -7 IRE, 0 allows sync bottom
// RQ22 - low-high-low toggle of timing reset bit resets timing counters
// RQ23 - master/slave and timing mode act only once pixel data valid is set
// RQ24 - serial writes are synchronised into the pixel clock before use
// RQ25 - field counter advances each field and wraps after its maximum
module vem_regs (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire vem_pkg::vem_wr_t wr_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  input wire logic timing_reset_pin_in,
  input wire logic standard_select_pin_in,
  input wire logic sleep_bit_in,
  input wire logic oversample_4x_select_in,
  input wire logic pal_mode_in,
  input wire logic pixel_data_valid_in,
  input wire logic [2:0] luma_filter_select_in,
  input wire logic field_boundary_in,
  input wire vem_pkg::vem_sync_t sync_in,
  input wire vem_pkg::vem_pix_t pix_in,
  output vem_pkg::vem_ctrl_t ctrl_out,
  output logic sleep_out,
  output logic timing_counter_reset_out,
  output logic [2:0] field_count_out,
  output logic sync_pin_out,
  output logic clamp_vsync_pin_out,
  output vem_pkg::vem_pix_t pix_out
);

  // -------------------------------------------------------------------------
  // state
  // -------------------------------------------------------------------------
  typedef struct packed {
    logic [2:0] strap_sync1;
    logic [2:0] strap_sync2;
    logic wr_tog_prev;
    logic strap_taken;
    logic [1:0] strap_fill;
    logic strap_sleep;
    logic [7:0] r_olcc;
    logic [7:0] r_pfc;
    logic [7:0] r_pae;
    logic [7:0] r_po;
    logic [7:0] r_llcd;
    logic [7:0] r_tcp;
    logic [7:0] r_tcs;
    logic [2:0] field_cnt;
    vem_pkg::vem_trst_state_t trst;
    logic [vem_pkg::CLAMP_TAPS-2:0] clamp_sr;
    logic [vem_pkg::LUMA_DLY_MAX-1:0][7:0] luma_dl;
    logic [vem_pkg::CHROMA_DLY_MAX-1:0][7:0] chroma_dl;
    logic [7:0] rd_data;
    vem_pkg::vem_ctrl_t ctrl;
    logic sleep;
    logic trst_pulse;
    logic sync_pin;
    logic clamp_vsync_pin;
    vem_pkg::vem_pix_t pix;
  } vem_state_t;

  vem_state_t st_r;
  vem_state_t st_nxt;

  assign rd_data_out = st_r.rd_data;
  assign ctrl_out = st_r.ctrl;
  assign sleep_out = st_r.sleep;
  assign timing_counter_reset_out = st_r.trst_pulse;
  assign field_count_out = st_r.field_cnt;
  assign sync_pin_out = st_r.sync_pin;
  assign clamp_vsync_pin_out = st_r.clamp_vsync_pin;
  assign pix_out = st_r.pix;

  // -------------------------------------------------------------------------
  // next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic wr_tog_s;
    logic wr_fire;
    logic [2:0] field_max;
    logic [1:0] clamp_dly;
    logic clamp_src;
    logic [7:0] luma_v;
    logic [7:0] chroma_v;
    logic [7:0] floor_v;
    logic [1:0] us_code;
    logic [2:0] luma_sel;
    logic [3:0] chroma_sel;
    logic eff_slave;
    logic [vem_pkg::CLAMP_TAPS-1:0] clamp_taps;
    st_nxt = st_r;
    clamp_taps = '0;
    wr_tog_s = 1'b0;
    wr_fire = 1'b0;
    field_max = vem_pkg::FIELD_MAX_NTSC;
    clamp_dly = 2'h0;
    clamp_src = 1'b0;
    luma_v = 8'h00;
    chroma_v = 8'h00;
    floor_v = vem_pkg::FLOOR_SYNC_BOTTOM;
    us_code = 2'h0;
    luma_sel = 3'h0;
    chroma_sel = 4'h0;
    eff_slave = 1'b0;

    // two-stage synchronisers; bit 2 carries the write toggle
    st_nxt.strap_sync1 = {wr_in.toggle, timing_reset_pin_in, standard_select_pin_in};
    st_nxt.strap_sync2 = st_r.strap_sync1;
    wr_tog_s = st_r.strap_sync2[2];
    st_nxt.wr_tog_prev = wr_tog_s;
    // address and data are held by the serial side for six clocks after the toggle
    wr_fire = wr_tog_s ^ st_r.wr_tog_prev; // [RQ24]

    // straps caught once, only after both synchroniser stages hold pin values
    st_nxt.strap_fill = {st_r.strap_fill[0], 1'b1};
    if (st_r.strap_fill[1] && !st_r.strap_taken) begin
      st_nxt.strap_taken = 1'b1;
      st_nxt.strap_sleep = st_r.strap_sync2[1] & st_r.strap_sync2[0]; // [RQ6]
    end

    // ---------------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------------
    if (wr_fire) begin
      unique case (wr_in.addr)
        vem_pkg::ADDR_OUTPUT_LEVEL_CLAMP_CONTROL: st_nxt.r_olcc = wr_in.data;
        vem_pkg::ADDR_POWER_FIELD_CONTROL: st_nxt.r_pfc = wr_in.data & vem_pkg::POWER_FIELD_WR_MASK;
        vem_pkg::ADDR_PICTURE_ADJUST_ENABLES: st_nxt.r_pae = wr_in.data;
        vem_pkg::ADDR_PROCESSING_OPTIONS: st_nxt.r_po = wr_in.data;
        vem_pkg::ADDR_LUMA_LIMIT_CHROMA_DELAY: st_nxt.r_llcd = wr_in.data;
        vem_pkg::ADDR_TIMING_CONTROL_PRIMARY: st_nxt.r_tcp = wr_in.data;
        vem_pkg::ADDR_TIMING_CONTROL_SYNC_SHAPE: st_nxt.r_tcs = wr_in.data;
        default: begin
        end
      endcase
    end

    // ---------------------------------------------------------------------
    // timing counter reset: low, high, low on the written bit
    // ---------------------------------------------------------------------
    st_nxt.trst_pulse = 1'b0;
    unique case (st_r.trst)
      vem_pkg::TR_IDLE: begin
        if (st_r.r_tcp[vem_pkg::TIMING_RESET_BIT]) begin
          st_nxt.trst = vem_pkg::TR_HIGH;
        end
      end
      vem_pkg::TR_HIGH: begin
        if (!st_r.r_tcp[vem_pkg::TIMING_RESET_BIT]) begin
          st_nxt.trst = vem_pkg::TR_FIRE;
        end
      end
      vem_pkg::TR_FIRE: begin
        st_nxt.trst_pulse = 1'b1; // [RQ22]
        st_nxt.trst = vem_pkg::TR_IDLE;
      end
      default: st_nxt.trst = vem_pkg::TR_IDLE;
    endcase

    // ---------------------------------------------------------------------
    // field counter
    // ---------------------------------------------------------------------
    field_max = pal_mode_in ? vem_pkg::FIELD_MAX_PAL : vem_pkg::FIELD_MAX_NTSC; // [RQ8]
    if (st_r.trst == vem_pkg::TR_FIRE) begin
      st_nxt.field_cnt = vem_pkg::FIELD_ZERO;
    end else if (field_boundary_in) begin
      if (st_r.field_cnt >= field_max) begin
        st_nxt.field_cnt = vem_pkg::FIELD_ZERO; // [RQ25]
      end else begin
        st_nxt.field_cnt = st_r.field_cnt + vem_pkg::FIELD_ONE; // [RQ25]
      end
    end

    // ---------------------------------------------------------------------
    // readback
    // ---------------------------------------------------------------------
    unique case (rd_addr_in)
      vem_pkg::ADDR_OUTPUT_LEVEL_CLAMP_CONTROL: st_nxt.rd_data = st_r.r_olcc;
      vem_pkg::ADDR_POWER_FIELD_CONTROL: begin
        st_nxt.rd_data = st_r.r_pfc;
        st_nxt.rd_data[vem_pkg::FIELD_COUNT_LSB +: 3] = st_r.field_cnt; // [RQ8]
      end
      vem_pkg::ADDR_PICTURE_ADJUST_ENABLES: st_nxt.rd_data = st_r.r_pae;
      vem_pkg::ADDR_PROCESSING_OPTIONS: st_nxt.rd_data = st_r.r_po;
      vem_pkg::ADDR_LUMA_LIMIT_CHROMA_DELAY: st_nxt.rd_data = st_r.r_llcd;
      vem_pkg::ADDR_TIMING_CONTROL_PRIMARY: st_nxt.rd_data = st_r.r_tcp;
      vem_pkg::ADDR_TIMING_CONTROL_SYNC_SHAPE: st_nxt.rd_data = st_r.r_tcs;
      default: st_nxt.rd_data = vem_pkg::UNMAPPED_READ;
    endcase

    // ---------------------------------------------------------------------
    // control outputs
    // ---------------------------------------------------------------------
    // master timing is forced until pixel data is declared valid
    eff_slave = pixel_data_valid_in & st_r.r_tcp[vem_pkg::SLAVE_BIT]; // [RQ23]
    st_nxt.ctrl.slave_mode = eff_slave;
    st_nxt.ctrl.timing_mode = pixel_data_valid_in ?
      st_r.r_tcp[vem_pkg::TIMING_MODE_LSB +: 2] : 2'h0; // [RQ23]
    st_nxt.ctrl.blank_input_en = st_r.r_tcp[vem_pkg::BLANK_IN_BIT];
    st_nxt.ctrl.y_level_smpte = st_r.r_olcc[vem_pkg::Y_LEVEL_BIT]; // [RQ1]
    st_nxt.ctrl.uv_level = st_r.r_olcc[vem_pkg::UV_LEVEL_LSB +: 2]; // [RQ2]
    st_nxt.ctrl.rgb_sync_all = st_r.r_olcc[vem_pkg::RGB_SYNC_BIT]; // [RQ3]
    // pll bit is passed as written; the host must clear it for 4x mode
    st_nxt.ctrl.pll_disable = st_r.r_pfc[vem_pkg::PLL_DISABLE_BIT]; // [RQ7]
    st_nxt.ctrl.color_ctrl_en = st_r.r_pae[vem_pkg::COLOR_CTRL_BIT]; // [RQ9]
    st_nxt.ctrl.luma_sat_en = st_r.r_pae[vem_pkg::LUMA_SAT_BIT]; // [RQ10]
    st_nxt.ctrl.hue_adj_en = st_r.r_pae[vem_pkg::HUE_ADJ_BIT]; // [RQ11]
    st_nxt.ctrl.brightness_en = st_r.r_pae[vem_pkg::BRIGHT_BIT]; // [RQ12]
    st_nxt.ctrl.sharpness_active = st_r.r_pae[vem_pkg::SHARP_BIT] &
      (luma_filter_select_in == vem_pkg::LUMA_FILTER_EXTENDED); // [RQ13]
    st_nxt.ctrl.double_buffer_active = st_r.r_po[vem_pkg::DBUF_BIT] & eff_slave; // [RQ16]
    st_nxt.ctrl.port_16bit = st_r.r_po[vem_pkg::PORT16_BIT]; // [RQ17]
    st_nxt.ctrl.noise_reduction_en = st_r.r_po[vem_pkg::NR_BIT]; // [RQ18]
    st_nxt.ctrl.gamma_en = st_r.r_po[vem_pkg::GAMMA_EN_BIT]; // [RQ18]
    st_nxt.ctrl.gamma_curve_b = st_r.r_po[vem_pkg::GAMMA_CURVE_BIT]; // [RQ18]
    st_nxt.ctrl.sync_shape = st_r.r_tcs;

    // sleep: strap decides until software takes over
    st_nxt.sleep = st_r.r_pfc[vem_pkg::PWRUP_SLEEP_CTL_BIT] ? sleep_bit_in : st_r.strap_sleep; // [RQ6]

    // ---------------------------------------------------------------------
    // sync pins and clamp placement
    // ---------------------------------------------------------------------
    st_nxt.sync_pin = st_r.r_pae[vem_pkg::CSO_SEL_BIT] ? sync_in.csync : sync_in.hsync; // [RQ14]
    clamp_src = st_r.r_olcc[vem_pkg::CLAMP_POS_BIT] ? sync_in.clamp_back : sync_in.clamp_front; // [RQ5]
    st_nxt.clamp_sr = {st_r.clamp_sr[vem_pkg::CLAMP_TAPS-3:0], clamp_src};
    clamp_taps = {st_r.clamp_sr, clamp_src};
    clamp_dly = st_r.r_olcc[vem_pkg::CLAMP_DELAY_LSB +: 2];
    // tap three is nominal, so the pulse can move three cycles either way
    if (st_r.r_olcc[vem_pkg::CLAMP_DIR_BIT]) begin
      clamp_src = clamp_taps[vem_pkg::CLAMP_SHIFT_MAX - int'(clamp_dly)]; // [RQ4]
    end else begin
      clamp_src = clamp_taps[vem_pkg::CLAMP_SHIFT_MAX + int'(clamp_dly)]; // [RQ4]
    end
    st_nxt.clamp_vsync_pin = st_r.r_pae[vem_pkg::CLAMP_SEL_BIT] ? clamp_src : sync_in.vsync; // [RQ15]

    // ---------------------------------------------------------------------
    // luma limiter and luma/chroma delay
    // ---------------------------------------------------------------------
    luma_v = pixel_data_valid_in ? pix_in.luma : vem_pkg::LUMA_BLACK; // [RQ23]
    chroma_v = pixel_data_valid_in ? pix_in.chroma : vem_pkg::CHROMA_ZERO; // [RQ23]
    us_code = st_r.r_llcd[vem_pkg::UNDERSHOOT_LSB +: 2];
    if (oversample_4x_select_in && us_code != vem_pkg::UNDERSHOOT_OFF) begin
      unique case (us_code)
        vem_pkg::UNDERSHOOT_M1P5: floor_v = vem_pkg::FLOOR_M1P5_IRE; // [RQ19]
        vem_pkg::UNDERSHOOT_M6: floor_v = vem_pkg::FLOOR_M6_IRE; // [RQ19]
        default: floor_v = vem_pkg::FLOOR_M11_IRE; // [RQ19]
      endcase
    end else if (st_r.r_tcp[vem_pkg::MIN_LUMA_BIT]) begin
      floor_v = vem_pkg::FLOOR_M7_IRE; // [RQ21]
    end else begin
      floor_v = vem_pkg::FLOOR_SYNC_BOTTOM; // [RQ21]
    end
    if (luma_v < floor_v) begin
      luma_v = floor_v;
    end
    // scaled input already arrives saturated at full scale; clip guards wider upstream sums
    if (st_r.r_pae[vem_pkg::LUMA_SAT_BIT] && luma_v > vem_pkg::LUMA_SAT_MAX) begin
      luma_v = vem_pkg::LUMA_SAT_MAX; // [RQ10]
    end

    st_nxt.luma_dl = {st_r.luma_dl[vem_pkg::LUMA_DLY_MAX-2:0], luma_v};
    st_nxt.chroma_dl = {st_r.chroma_dl[vem_pkg::CHROMA_DLY_MAX-2:0], chroma_v};
    // luma code steps in pairs of clocks: 0, 2, 4, 6
    luma_sel = 3'(int'(st_r.r_tcp[vem_pkg::LUMA_DLY_LSB +: 2]) * vem_pkg::LUMA_DLY_STEP);
    // chroma code: 0, 2, 4, 8 clocks
    unique case (st_r.r_llcd[vem_pkg::CHROMA_DLY_LSB +: 2])
      2'h0: chroma_sel = 4'h0;
      2'h1: chroma_sel = 4'h2;
      2'h2: chroma_sel = 4'h4;
      default: chroma_sel = 4'h8;
    endcase
    st_nxt.pix.luma = (luma_sel == 3'h0) ? luma_v : st_r.luma_dl[luma_sel - 3'h1]; // [RQ20]
    st_nxt.pix.chroma = (chroma_sel == 4'h0) ? chroma_v : st_r.chroma_dl[chroma_sel - 4'h1]; // [RQ20]

    // ---------------------------------------------------------------------
    // synchronous reset
    // ---------------------------------------------------------------------
    if (sys_rst_in) begin
      st_nxt = '0;
      st_nxt.r_olcc = vem_pkg::REG_RESET;
      st_nxt.r_pfc = vem_pkg::REG_RESET;
      st_nxt.r_pae = vem_pkg::REG_RESET;
      st_nxt.r_po = vem_pkg::REG_RESET;
      st_nxt.r_llcd = vem_pkg::REG_RESET;
      st_nxt.r_tcp = vem_pkg::REG_RESET;
      st_nxt.r_tcs = vem_pkg::REG_RESET;
      st_nxt.trst = vem_pkg::TR_IDLE;
      st_nxt.pix.luma = vem_pkg::LUMA_BLACK;
      st_nxt.pix.chroma = vem_pkg::CHROMA_ZERO;
    end
  end

  always_ff @(posedge clk_in) begin
    st_r <= st_nxt;
  end

endmodule : vem_regs

//--- src/vem_pkg.sv
// package: register map, field layout and timing constants of the mode/timing register bank
package vem_pkg;

  // -------------------------------------------------------------------------
  // register offsets (subaddress)
  // -------------------------------------------------------------------------
  localparam logic [7:0] ADDR_OUTPUT_LEVEL_CLAMP_CONTROL = 8'h05;
  localparam logic [7:0] ADDR_POWER_FIELD_CONTROL = 8'h06;
  localparam logic [7:0] ADDR_PICTURE_ADJUST_ENABLES = 8'h07;
  localparam logic [7:0] ADDR_PROCESSING_OPTIONS = 8'h08;
  localparam logic [7:0] ADDR_LUMA_LIMIT_CHROMA_DELAY = 8'h09;
  localparam logic [7:0] ADDR_TIMING_CONTROL_PRIMARY = 8'h0A;
  localparam logic [7:0] ADDR_TIMING_CONTROL_SYNC_SHAPE = 8'h0B;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // -------------------------------------------------------------------------
  // field positions
  // -------------------------------------------------------------------------
  // output_level_clamp_control
  localparam int Y_LEVEL_BIT = 0;
  localparam int UV_LEVEL_LSB = 1;
  localparam int RGB_SYNC_BIT = 3;
  localparam int CLAMP_DELAY_LSB = 4;
  localparam int CLAMP_DIR_BIT = 6;
  localparam int CLAMP_POS_BIT = 7;
  // power_field_control
  localparam int PWRUP_SLEEP_CTL_BIT = 0;
  localparam int PLL_DISABLE_BIT = 1;
  localparam int FIELD_COUNT_LSB = 5;
  localparam logic [7:0] POWER_FIELD_WR_MASK = 8'h1F;
  // picture_adjust_enables
  localparam int COLOR_CTRL_BIT = 0;
  localparam int LUMA_SAT_BIT = 1;
  localparam int HUE_ADJ_BIT = 2;
  localparam int BRIGHT_BIT = 3;
  localparam int SHARP_BIT = 4;
  localparam int CSO_SEL_BIT = 5;
  localparam int CLAMP_SEL_BIT = 7;
  // processing_options
  localparam int DBUF_BIT = 2;
  localparam int PORT16_BIT = 3;
  localparam int NR_BIT = 5;
  localparam int GAMMA_EN_BIT = 6;
  localparam int GAMMA_CURVE_BIT = 7;
  // luma_limit_chroma_delay
  localparam int UNDERSHOOT_LSB = 0;
  localparam int CHROMA_DLY_LSB = 4;
  // timing_control_primary
  localparam int SLAVE_BIT = 0;
  localparam int TIMING_MODE_LSB = 1;
  localparam int BLANK_IN_BIT = 3;
  localparam int LUMA_DLY_LSB = 4;
  localparam int MIN_LUMA_BIT = 6;
  localparam int TIMING_RESET_BIT = 7;

  // -------------------------------------------------------------------------
  // encodings and levels
  // -------------------------------------------------------------------------
  localparam logic [2:0] LUMA_FILTER_EXTENDED = 3'h4;
  localparam logic [2:0] FIELD_MAX_NTSC = 3'h3;
  localparam logic [2:0] FIELD_MAX_PAL = 3'h7;
  localparam logic [2:0] FIELD_ONE = 3'h1;
  localparam logic [2:0] FIELD_ZERO = 3'h0;

  localparam logic [1:0] UNDERSHOOT_OFF = 2'h0;
  localparam logic [1:0] UNDERSHOOT_M1P5 = 2'h1;
  localparam logic [1:0] UNDERSHOOT_M6 = 2'h2;
  // luma floors as 8-bit codes at the limiter (sync bottom = 0)
  localparam logic [7:0] FLOOR_SYNC_BOTTOM = 8'h00;
  localparam logic [7:0] FLOOR_M7_IRE = 8'h30;
  localparam logic [7:0] FLOOR_M1P5_IRE = 8'h3B;
  localparam logic [7:0] FLOOR_M6_IRE = 8'h34;
  localparam logic [7:0] FLOOR_M11_IRE = 8'h2C;
  localparam logic [7:0] LUMA_SAT_MAX = 8'hFF;
  localparam logic [7:0] LUMA_BLACK = 8'h10;
  localparam logic [7:0] CHROMA_ZERO = 8'h80;

  // -------------------------------------------------------------------------
  // timing
  // -------------------------------------------------------------------------
  localparam int PIXEL_CLK_MHZ = 27;
  localparam int LUMA_DLY_MAX_NS = 222;
  // rounded to whole clocks: truncation would lose the last tap
  localparam int LUMA_DLY_MAX = (LUMA_DLY_MAX_NS * PIXEL_CLK_MHZ + 500) / 1000;
  localparam int CHROMA_DLY_MAX = 8;
  localparam int LUMA_DLY_STEP = 2;
  localparam int CLAMP_SHIFT_MAX = 3;
  localparam int CLAMP_TAPS = 2 * CLAMP_SHIFT_MAX + 1;

  // -------------------------------------------------------------------------
  // carriers
  // -------------------------------------------------------------------------
  typedef enum logic [2:0] {
    TR_IDLE = 3'b001,
    TR_HIGH = 3'b010,
    TR_FIRE = 3'b100
  } vem_trst_state_t;

  typedef struct packed {
    logic y_level_smpte;
    logic [1:0] uv_level;
    logic rgb_sync_all;
    logic pll_disable;
    logic color_ctrl_en;
    logic luma_sat_en;
    logic hue_adj_en;
    logic brightness_en;
    logic sharpness_active;
    logic double_buffer_active;
    logic port_16bit;
    logic noise_reduction_en;
    logic gamma_en;
    logic gamma_curve_b;
    logic slave_mode;
    logic [1:0] timing_mode;
    logic blank_input_en;
    logic [7:0] sync_shape;
  } vem_ctrl_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic toggle;
  } vem_wr_t;

  typedef struct packed {
    logic [7:0] luma;
    logic [7:0] chroma;
  } vem_pix_t;

  typedef struct packed {
    logic csync;
    logic hsync;
    logic vsync;
    logic clamp_front;
    logic clamp_back;
  } vem_sync_t;

endpackage : vem_pkg

//--- sim/vem_props.sv
// checker: port-level properties of the mode and timing register bank
module vem_props (
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic pixel_data_valid_in,
  input wire logic [2:0] luma_filter_select_in,
  input wire logic field_boundary_in,
  input wire logic pal_mode_in,
  input wire vem_pkg::vem_ctrl_t ctrl_out,
  input wire logic timing_counter_reset_out,
  input wire logic [2:0] field_count_out,
  input wire vem_pkg::vem_pix_t pix_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  a_sharp_needs_ext: assert property (
    ctrl_out.sharpness_active |-> $past(luma_filter_select_in) == 3'h4) else $error("sharpness on without extended filter");
  a_dbuf_slave_only: assert property (
    ctrl_out.double_buffer_active |-> ctrl_out.slave_mode) else $error("double buffering active in master timing");
  a_mode_needs_valid: assert property (
    (ctrl_out.slave_mode || ctrl_out.timing_mode != 2'h0) |-> $past(pixel_data_valid_in)) else $error("mode before valid");
  a_blank_chroma: assert property (
    (!pixel_data_valid_in)[*8] ##1 (!pixel_data_valid_in)[*2] |=> pix_out.chroma == 8'h80) else $error("pixels not blanked");
  a_field_step: assert property (
    field_boundary_in && field_count_out < (pal_mode_in ? 3'h7 : 3'h3)
    |=> timing_counter_reset_out || field_count_out == $past(field_count_out) + 3'h1) else $error("field count missed step");
  a_field_wrap: assert property (
    field_boundary_in && field_count_out == (pal_mode_in ? 3'h7 : 3'h3) |=> field_count_out == 3'h0) else $error("no wrap");
  a_field_hold: assert property (
    !field_boundary_in |=> timing_counter_reset_out || $stable(field_count_out)) else $error("field count moved idle");
  a_trst_one_cycle: assert property (
    $rose(timing_counter_reset_out) |=> !timing_counter_reset_out) else $error("timing reset pulse too long");
  a_trst_clears: assert property (
    timing_counter_reset_out |-> field_count_out == 3'h0) else $error("timing reset left field count");
endmodule : vem_props

bind vem_regs vem_props props (.clk_in, .sys_rst_in, .pixel_data_valid_in, .luma_filter_select_in, .field_boundary_in,
  .pal_mode_in, .ctrl_out, .timing_counter_reset_out, .field_count_out, .pix_out);

//--- sim/vem_host.sv
// partner model: host writing registers through the serial engine's toggle handshake
module vem_host (
  input wire logic clk_in,
  output vem_pkg::vem_wr_t wr_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial wr_out = '0;
  // addr/data settle before the toggle and stay past the capture window
  task automatic write(input logic [7:0] addr, input logic [7:0] data);
    @(negedge clk_in);
    wr_out.addr = addr;
    wr_out.data = data;
    @(negedge clk_in);
    wr_out.toggle = ~wr_out.toggle;
    repeat (6) @(negedge clk_in);
    wr_out.addr = ~addr;
    wr_out.data = ~data;
  endtask : write
  task automatic timing_reset(input logic [7:0] base);
    write(8'h0A, base | 8'h80);
    write(8'h0A, base & 8'h7F);
  endtask : timing_reset
  // oversampling at 4x needs the pll running
  task automatic select_4x(input logic [7:0] pwr);
    write(8'h06, pwr & 8'hFD);
  endtask : select_4x
endmodule : vem_host

//--- sim/video_encoder_mode_timing_regs_test.sv
// testbench: register bank table, pins, pixels and field counter
module video_encoder_mode_timing_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] addr; logic [7:0] data; logic [7:0] exp;} vem_row_t;
  logic clk_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic [7:0] rd_addr_in = 8'h00;
  logic sleep_bit = 1'b0, os4x = 1'b0, pal = 1'b0, valid = 1'b0, fb = 1'b0;
  logic [2:0] lfs = 3'h4;
  logic strap = 1'b1;
  vem_pkg::vem_sync_t sync_in = '0;
  vem_pkg::vem_pix_t pix_in = '0;
  vem_pkg::vem_wr_t wr;
  vem_pkg::vem_ctrl_t ctrl;
  vem_pkg::vem_pix_t pix_out;
  logic [7:0] rd_data, n;
  logic [2:0] fc;
  logic sleep, trst, spin, cpin;
  int n_errors = 0;
  int n_tests = 0;
  int n_pulse = 0;
  vem_row_t rows [8] = '{'{8'h05, 8'hA5, 8'hA5}, '{8'h06, 8'hFF, 8'h1F}, '{8'h07, 8'hFF, 8'hFF}, '{8'h08, 8'hEC, 8'hEC},
    '{8'h09, 8'h33, 8'h33}, '{8'h0A, 8'h5E, 8'h5E}, '{8'h0B, 8'h3C, 8'h3C}, '{8'h0C, 8'h77, 8'h00}};
  always #20 clk_in = ~clk_in;
  always @(negedge clk_in) if (trst) n_pulse++;
  vem_host host (.clk_in(clk_in), .wr_out(wr));
  vem_regs uut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .wr_in(wr), .rd_addr_in(rd_addr_in), .rd_data_out(rd_data),
    .timing_reset_pin_in(strap), .standard_select_pin_in(strap), .sleep_bit_in(sleep_bit),
    .oversample_4x_select_in(os4x), .pal_mode_in(pal), .pixel_data_valid_in(valid), .luma_filter_select_in(lfs),
    .field_boundary_in(fb), .sync_in(sync_in), .pix_in(pix_in), .ctrl_out(ctrl), .sleep_out(sleep),
    .timing_counter_reset_out(trst), .field_count_out(fc), .sync_pin_out(spin), .clamp_vsync_pin_out(cpin),
    .pix_out(pix_out));
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
    @(negedge clk_in);
    rd_addr_in = addr;
    @(negedge clk_in);
    check("read data", rd_data, exp);
  endtask : rd
  task automatic fields(input int cnt);
    repeat (cnt) begin
      @(negedge clk_in);
      fb = 1'b1;
      @(negedge clk_in);
      fb = 1'b0;
    end
  endtask : fields
  // counts edges until the pin rises; gives up at 20
  task automatic measure(input logic clamp_pin);
    n = 8'h00;
    do begin
      @(posedge clk_in);
      #1;
      n++;
    end while ((clamp_pin ? cpin : spin) !== 1'b1 && n < 8'd20);
  endtask : measure
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (4000) @(posedge clk_in);
    n_errors++;
    tally_and_finish();
  end
  initial begin
    repeat (3) @(posedge clk_in);
    @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check("strap sleep", 8'(sleep), 8'h01);
    check("blank chroma", pix_out.chroma, 8'h80);
    // ----------------------------------------------------------------
    // register table: reset value, write, readback
    // ----------------------------------------------------------------
    for (int i = 0; i < 8; i++) begin
      rd(rows[i].addr, 8'h00);
      host.write(rows[i].addr, rows[i].data);
      rd(rows[i].addr, rows[i].exp);
    end
    check("handed sleep", 8'(sleep), 8'h00);
    check("y level", 8'(ctrl.y_level_smpte), 8'h01);
    check("uv level", 8'(ctrl.uv_level), 8'h02);
    check("rgb sync", 8'(ctrl.rgb_sync_all), 8'h00);
    check("enables", 8'({ctrl.color_ctrl_en, ctrl.luma_sat_en, ctrl.hue_adj_en, ctrl.brightness_en}), 8'h0F);
    check("options", 8'({ctrl.port_16bit, ctrl.noise_reduction_en, ctrl.gamma_en, ctrl.gamma_curve_b}), 8'h0F);
    check("master until valid", 8'({ctrl.slave_mode, ctrl.timing_mode}), 8'h00);
    check("sharpness", 8'(ctrl.sharpness_active), 8'h01);
    @(negedge clk_in);
    lfs = 3'h3;
    repeat (2) @(negedge clk_in);
    check("sharpness", 8'(ctrl.sharpness_active), 8'h00);
    lfs = 3'h4;
    os4x = 1'b1;
    host.select_4x(8'h1F);
    check("pll disable", 8'(ctrl.pll_disable), 8'h00);
    valid = 1'b1;
    repeat (6) @(negedge clk_in);
    check("mode", 8'({ctrl.slave_mode, ctrl.timing_mode, ctrl.double_buffer_active}), 8'h06);
    check("floor 4x", pix_out.luma, 8'h2C);
    os4x = 1'b0;
    host.write(8'h0A, 8'h5F);
    check("slave mode", 8'({ctrl.slave_mode, ctrl.timing_mode, ctrl.double_buffer_active}), 8'h0F);
    check("floor min luma", pix_out.luma, 8'h30);
    pix_in.luma = 8'h90;
    repeat (2) @(negedge clk_in);
    check("luma delay", pix_out.luma, 8'h30);
    @(negedge clk_in);
    check("luma delay", pix_out.luma, 8'h90);
    pal = 1'b1;
    fields(9);
    rd(8'h06, 8'h3D);
    host.timing_reset(8'h5F);
    rd(8'h06, 8'h1D);
    check("reset pulses", 8'(n_pulse), 8'h01);
    pal = 1'b0;
    fields(5);
    rd(8'h06, 8'h3D);
    sync_in.csync = 1'b1;
    measure(1'b0);
    check("sync latency", n, 8'h01);
    host.write(8'h07, 8'h1F);
    check("hsync select", 8'({spin, cpin}), 8'h00);
    host.write(8'h07, 8'hFF);
    sync_in.clamp_back = 1'b1;
    measure(1'b1);
    check("clamp back delay", n, 8'h06);
    @(negedge clk_in);
    sync_in.clamp_back = 1'b0;
    host.write(8'h05, 8'h71);
    sync_in.clamp_front = 1'b1;
    measure(1'b1);
    check("clamp front advance", n, 8'h01);
    @(negedge clk_in);
    strap = 1'b0;
    sys_rst_in = 1'b1;
    repeat (3) @(negedge clk_in);
    sys_rst_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check("strap awake", 8'(sleep), 8'h00);
    tally_and_finish();
  end
endmodule : video_encoder_mode_timing_regs_test
